// File: design/ords_regs.vh
// constants for the display reset defaults and serial command port
`ifndef ORDS_REGS_VH
`define ORDS_REGS_VH
`define ORDS_CONTRAST_RST 8'h49
`define ORDS_MUX_96 7'h5f
`define ORDS_START_RST 7'h00
`define ORDS_COL_RST 7'h00
`define ORDS_BITS_PER_BYTE 4'h8
`define ORDS_CMD_DISP_OFF 8'hae
`define ORDS_CMD_DISP_ON 8'haf
`define ORDS_CMD_FOLLOW_RAM 8'ha4
`define ORDS_CMD_ALL_ON 8'ha5
`define ORDS_CMD_NORMAL 8'ha6
`define ORDS_CMD_INVERSE 8'ha7
`define ORDS_CMD_REMAP_OFF 8'ha0
`define ORDS_CMD_REMAP_ON 8'ha1
`define ORDS_CMD_SCAN_NORM 8'hc0
`define ORDS_CMD_SCAN_REV 8'hc8
`define ORDS_CMD_CONTRAST 8'h81
`define ORDS_CMD_MUX 8'ha8
`define ORDS_START_BASE 8'h40
`define ORDS_COL_LAST 7'h5f
`endif

// File: design/ords_sync.v
// two flip-flop synchroniser for the serial pins
`timescale 1ns/1ns
`default_nettype none
module ords_sync #(
  parameter W = 4
) (
  input wire mclk, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire [W-1:0] din, // asynchronous pins
  output reg [W-1:0] dout // synchronised copies
);
  reg [W-1:0] meta; // first stage, read only by dout

  // two stages per bit; reset holds idle-high levels
  always @(posedge mclk) begin
    if (!rst_n) begin
      meta <= {W{1'b1}};
      dout <= {W{1'b1}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// File: design/ords_top.v
// serial command/data port and display state of the display driver
`timescale 1ns/1ns
`default_nettype none
`include "ords_regs.vh"
module ords_top (
  input wire mclk, // 10 MHz system clock
  input wire rst_n, // synchronous reset, active low
  input wire panel_init_n, // panel reset pin, active low
  input wire cs_n, // chip select pin, active low
  input wire cmd_data_select, // low command, high data
  input wire sclk, // serial shift clock pin
  input wire sdin, // serial data pin
  output reg display_on, // panel drive enabled
  output reg [6:0] mux_ratio, // multiplex ratio minus one
  output reg seg_remap, // first_segment_driver remap
  output reg com_remap, // first_common_driver remap
  output reg scan_reverse, // common scan reversed
  output reg [6:0] start_line, // display start line
  output reg [6:0] col_addr, // column address counter
  output reg [7:0] contrast, // contrast setting
  output reg all_on, // entire display on, ignore memory
  output reg inverse, // inverse display
  output reg cmd_strobe, // one-cycle pulse, command byte
  output reg data_strobe, // one-cycle pulse, data byte
  output reg [7:0] rx_byte, // last received byte
  output reg [7:0] data_out, // data byte to memory
  output reg [6:0] data_col // column for data_out
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisation
  // every host pin arrives with no relation to mclk, so each one passes
  // two flip-flops before any logic looks at it; all five share the
  // same delay, which keeps data and select aligned with the shift
  // clock as the edge detector below sees it
  wire [4:0] pins_s; // synchronised pins
  ords_sync #(.W(5)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({panel_init_n, cs_n, cmd_data_select, sclk, sdin}),
    .dout(pins_s)
  );
  wire init_n_s = pins_s[4]; // panel reset level
  wire cs_n_s = pins_s[3]; // select level
  wire sel_s = pins_s[2]; // command/data level
  wire sclk_s = pins_s[1]; // shift clock level
  wire sdin_s = pins_s[0]; // data level

  // edge detection on the synchronised shift clock; the previous level
  // resets high, the idle level of the pin, so no false edge follows
  reg sclk_d; // previous shift clock
  wire sclk_rise = sclk_s & ~sclk_d; // rising shift edge
  // the panel reset pin acts like the system reset, but is seen two
  // cycles late because it passes the synchroniser first
  wire clr = ~rst_n | ~init_n_s; // either reset

  ////////////////////////////////////////////////////////////////////
  // serial shift register
  // seven bits are held; the eighth goes straight into the completed
  // byte, so a byte is handed on in the cycle after its last edge.
  // a deselect clears only the bit count: stale bits in shreg are
  // shifted out by the next seven edges and never reach a byte
  reg [6:0] shreg; // partial byte
  reg [3:0] bitcnt; // bits gathered
  reg byte_done; // byte completed this cycle
  reg byte_is_data; // its command/data level
  reg [7:0] byte_val; // completed byte

  // shifts msb first on rising clock while selected
  // a bit is taken only on a detected rise while the synchronised
  // select is low; the host must hold each clock level for at least
  // two mclk cycles or a pulse may slip between two samples and
  // the byte would come up one bit short
  always @(posedge mclk) begin
    if (clr) begin
      sclk_d <= 1'b1;
      shreg <= 7'h00;
      bitcnt <= 4'h0;
      byte_done <= 1'b0;
      byte_is_data <= 1'b0;
      byte_val <= 8'h00;
    end else begin
      sclk_d <= sclk_s;
      byte_done <= 1'b0;
      // deselect drops any partial byte
      if (cs_n_s) begin
        bitcnt <= 4'h0;
      end else if (sclk_rise) begin
        shreg <= {shreg[5:0], sdin_s};
        // eighth bit: hand the byte on with its select level
        if (bitcnt == `ORDS_BITS_PER_BYTE - 4'h1) begin
          bitcnt <= 4'h0;
          byte_done <= 1'b1;
          byte_val <= {shreg, sdin_s};
          byte_is_data <= sel_s;
        end else begin
          bitcnt <= bitcnt + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // command interpreter
  // two opcodes take the following command byte as their argument; the
  // interpreter waits for it in a state of its own, so an argument is
  // never decoded as an opcode. data bytes leave that state untouched.
  // opcodes not decoded here are ignored and leave all state as it
  // was, which keeps an init sequence with extra opcodes harmless
  localparam ST_IDLE = 3'b001; // expecting opcode
  localparam ST_CONTRAST = 3'b010; // expecting contrast value
  localparam ST_MUX = 3'b100; // expecting multiplex value
  reg [2:0] state; // interpreter state

  // decodes command bytes and handles data writes
  // outside the two resets, every state output changes only on the cycle of a completed byte,
  // together with its strobe, so a consumer may latch on the strobe
  // and needs no other qualifier
  always @(posedge mclk) begin
    if (clr) begin
      // both resets restore the power-on defaults
      state <= ST_IDLE;
      display_on <= 1'b0;
      mux_ratio <= `ORDS_MUX_96;
      seg_remap <= 1'b0;
      com_remap <= 1'b0;
      start_line <= `ORDS_START_RST;
      col_addr <= `ORDS_COL_RST;
      scan_reverse <= 1'b0;
      contrast <= `ORDS_CONTRAST_RST;
      all_on <= 1'b0;
      inverse <= 1'b0;
      cmd_strobe <= 1'b0;
      data_strobe <= 1'b0;
      rx_byte <= 8'h00;
      data_out <= 8'h00;
      data_col <= 7'h00;
    end else begin
      // strobes default low, so each lasts one cycle
      cmd_strobe <= 1'b0;
      data_strobe <= 1'b0;
      if (byte_done) begin
        rx_byte <= byte_val;
        if (byte_is_data) begin
          // data byte: write at column, then advance
          // the column wraps after the last one, so a full row of
          // data needs no new column command
          data_strobe <= 1'b1;
          data_out <= byte_val;
          data_col <= col_addr;
          if (col_addr == `ORDS_COL_LAST) begin
            col_addr <= 7'h00;
          end else begin
            col_addr <= col_addr + 7'h01;
          end
        end else begin
          cmd_strobe <= 1'b1;
          case (state)
            // argument byte of the contrast opcode
            ST_CONTRAST: begin
              contrast <= byte_val;
              state <= ST_IDLE;
            end
            // argument byte of the multiplex opcode
            ST_MUX: begin
              mux_ratio <= byte_val[6:0];
              state <= ST_IDLE;
            end
            // opcode byte
            default: begin
              state <= ST_IDLE;
              // single-byte opcodes set or clear one mode each, the two scan opcodes two
              if (byte_val == `ORDS_CMD_DISP_OFF) begin
                display_on <= 1'b0;
              end else if (byte_val == `ORDS_CMD_DISP_ON) begin
                display_on <= 1'b1;
              end else if (byte_val == `ORDS_CMD_FOLLOW_RAM) begin
                all_on <= 1'b0;
              end else if (byte_val == `ORDS_CMD_ALL_ON) begin
                all_on <= 1'b1;
              end else if (byte_val == `ORDS_CMD_NORMAL) begin
                inverse <= 1'b0;
              end else if (byte_val == `ORDS_CMD_INVERSE) begin
                inverse <= 1'b1;
              end else if (byte_val == `ORDS_CMD_REMAP_OFF) begin
                seg_remap <= 1'b0;
              end else if (byte_val == `ORDS_CMD_REMAP_ON) begin
                seg_remap <= 1'b1;
              end else if (byte_val == `ORDS_CMD_SCAN_NORM) begin
                scan_reverse <= 1'b0;
                com_remap <= 1'b0;
              end else if (byte_val == `ORDS_CMD_SCAN_REV) begin
                scan_reverse <= 1'b1;
                com_remap <= 1'b1;
              end else if (byte_val == `ORDS_CMD_CONTRAST) begin
                state <= ST_CONTRAST;
              end else if (byte_val == `ORDS_CMD_MUX) begin
                state <= ST_MUX;
              end else if (byte_val[7:6] == 2'b01) begin
                start_line <= {1'b0, byte_val[5:0]};
              end
            end
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/ords_top_props.sv
// assertions on the serial port and display state
`timescale 1ns/1ns
`default_nettype none
module ords_top_props (
  input wire logic mclk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic panel_init_n, // panel reset pin
  input wire logic cs_n, // chip select pin
  input wire logic cmd_data_select, // command/data pin
  input wire logic sclk, // shift clock pin
  input wire logic sdin, // serial data pin
  input wire logic display_on, // panel drive
  input wire logic seg_remap, // segment remap
  input wire logic com_remap, // common remap
  input wire logic scan_reverse, // common scan reversed
  input wire logic all_on, // entire display on
  input wire logic inverse, // inverse display
  input wire logic cmd_strobe, // command byte pulse
  input wire logic data_strobe, // data byte pulse
  input wire logic [6:0] mux_ratio, // multiplex ratio
  input wire logic [6:0] start_line, // start line
  input wire logic [6:0] col_addr, // column counter
  input wire logic [6:0] data_col, // column of data byte
  input wire logic [7:0] contrast, // contrast setting
  input wire logic [7:0] rx_byte, // last byte
  input wire logic [7:0] data_out // data byte
);
  ////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // defaults show one edge after a low reset
  rst_mode_a: assert property (disable iff (1'b0) !rst_n
    |=> !display_on && mux_ratio == 7'h5f && contrast == 8'h49)
    else $error("reset mode wrong");
  rst_map_a: assert property (disable iff (1'b0) !rst_n
    |=> !seg_remap && !com_remap && !scan_reverse && !all_on && !inverse)
    else $error("reset mapping wrong");
  rst_addr_a: assert property (disable iff (1'b0) !rst_n
    |=> !start_line && !col_addr && !cmd_strobe && !data_strobe)
    else $error("reset address wrong");
  // strobes are single pulses, never both at once
  cmd_pulse_a: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("command strobe too long");
  data_pulse_a: assert property (data_strobe |-> !cmd_strobe ##1 !data_strobe)
    else $error("data strobe wrong");
  // data byte and column advance with wrap
  data_byte_a: assert property (data_strobe |-> data_out == rx_byte &&
    col_addr == (data_col == 7'h5f ? 7'h00 : data_col + 7'h01))
    else $error("data byte or column wrong");
  disp_on_a: assert property ($rose(display_on)
    |-> cmd_strobe && rx_byte == 8'haf) else $error("display on cause");
  // a byte only completes while selected
  sel_byte_a: assert property ((cmd_strobe || data_strobe)
    |-> $past(cs_n, 6) == 1'b0) else $error("byte without select");
endmodule
bind ords_top ords_top_props u_props (.*);
`default_nettype wire

// File: verif/ords_host.sv
// host model that bit-bangs command and data bytes
`timescale 1ns/1ns
`default_nettype none
module ords_host (
  input wire logic mclk, // system clock
  output var logic cs_n = 1'b1, // chip select, active low
  output var logic dcs = 1'b0, // command/data select
  output var logic sclk = 1'b1, // shift clock, idles high
  output var logic sdin = 1'b0 // serial data
);
  ////////////////////////////////////////////////////////////
  // send top n bits of b msb first, 800 ns clock, then deselect
  task automatic send(input logic [7:0] b, input logic is_data,
      input int n);
    int i;
    @(posedge mclk) dcs <= is_data;
    @(posedge mclk) cs_n <= 1'b0;
    for (i = 7; i > 7 - n; i--) begin
      @(posedge mclk) sclk <= 1'b0;
      sdin <= b[i];
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      repeat (3) @(posedge mclk);
    end
    @(posedge mclk) cs_n <= 1'b1;
    sdin <= ~sdin; // released line shows no stale bit
    repeat (4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// File: verif/ords_top_tb.sv
// self-checking bench for the serial command port
`timescale 1ns/1ns
`default_nettype none
module ords_top_tb;
  logic mclk = 1'b0; // system clock
  logic rst_n = 1'b0; // reset, active low
  logic panel_init_n = 1'b1; // panel reset pin
  wire cs_n, cmd_data_select, sclk, sdin; // host pins
  logic display_on, seg_remap, com_remap, scan_reverse, all_on, inverse;
  logic cmd_strobe, data_strobe; // byte pulses
  logic [6:0] mux_ratio, start_line, col_addr, data_col; // state
  logic [7:0] contrast, rx_byte, data_out, last_data; // bytes
  int errors = 0, comparisons = 0, cyc = 0, ncmd = 0; // counters
  initial begin
    forever #50 mclk = ~mclk;
  end
  ords_top dut_u (.*);
  ords_host host_u (.mclk(mclk), .cs_n(cs_n), .dcs(cmd_data_select),
    .sclk(sclk), .sdin(sdin));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // count command strobes, keep data, cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cmd_strobe === 1'b1) ncmd <= ncmd + 1;
    if (data_strobe === 1'b1) last_data <= data_out;
    if (cyc == 6000) begin
      errors = errors + 1;
      close_out;
    end
  end
  // defaults straight after reset; also after panel reset
  task automatic t_defaults;
    @(negedge mclk);
    chk("display_on", display_on, 8'h00);
    chk("mux_ratio", mux_ratio, 8'h5f);
    chk("remap", {seg_remap, com_remap}, 8'h00);
    chk("start_line", start_line, 8'h00);
    chk("col_addr", col_addr, 8'h00);
    chk("scan_reverse", scan_reverse, 8'h00);
    chk("contrast", contrast, 8'h49);
    chk("all_on", {all_on, inverse}, 8'h00);
  endtask
  // init sequence, off first and on last, unknown codes mixed in
  task automatic t_init;
    logic [7:0] seq [13] = '{8'hae, 8'hd5, 8'he1, 8'ha8, 8'h5f, 8'h40,
      8'ha1, 8'hc8, 8'h81, 8'h67, 8'ha4, 8'ha6, 8'haf};
    foreach (seq[i]) host_u.send(seq[i], 1'b0, 8);
    chk("cmd count", ncmd, 8'd13);
    chk("display_on", display_on, 8'h01);
    chk("remap", {seg_remap, com_remap, scan_reverse}, 8'h07);
    chk("contrast", contrast, 8'h67);
  endtask
  // data byte goes to memory and advances the column
  task automatic t_data;
    host_u.send(8'h5a, 1'b1, 8);
    chk("data_out", last_data, 8'h5a);
    chk("col_addr", col_addr, 8'h01);
    chk("cmd count", ncmd, 8'd13);
  endtask
  // all_on, multiplex and start line set to values the init sequence did not use, and a second data byte
  task automatic t_modes;
    host_u.send(8'ha5, 1'b0, 8);
    host_u.send(8'ha8, 1'b0, 8);
    host_u.send(8'h3f, 1'b0, 8);
    host_u.send(8'h45, 1'b0, 8);
    host_u.send(8'hc3, 1'b1, 8);
    chk("all_on", all_on, 8'h01);
    chk("mux_ratio", mux_ratio, 8'h3f);
    chk("start_line", start_line, 8'h05);
    chk("data_col", data_col, 8'h01);
    chk("data_out", last_data, 8'hc3);
    chk("col_addr", col_addr, 8'h02);
    chk("cmd count", ncmd, 8'd17);
  endtask
  // partial byte dropped, next byte taken, panel reset recovers
  task automatic t_abort;
    host_u.send(8'ha7, 1'b0, 5);
    chk("cmd count", ncmd, 8'd17);
    host_u.send(8'ha7, 1'b0, 8);
    chk("inverse", inverse, 8'h01);
    panel_init_n <= 1'b0;
    repeat (12) @(posedge mclk);
    panel_init_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_defaults;
    host_u.send(8'ha1, 1'b0, 8);
    chk("seg_remap", seg_remap, 8'h01);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_defaults;
    t_init;
    t_data;
    t_modes;
    t_abort;
    close_out;
  end
endmodule
`default_nettype wire
